/* verilog/iolm_pkg.sv */
// constants for the I/O line mux and write-mask block
package iolm_pkg;
	localparam int LINES = 32;
	localparam logic [7:0] OFF_OUTLEVEL = 8'h00;
	localparam logic [7:0] OFF_PULLUP_ON = 8'h04;
	localparam logic [7:0] OFF_PULLUP_OFF = 8'h08;
	localparam logic [7:0] OFF_PULLUP_STATE = 8'h0C;
	localparam logic [7:0] OFF_FUNC_A = 8'h10;
	localparam logic [7:0] OFF_FUNC_B = 8'h14;
	localparam logic [7:0] OFF_FUNC_STATE = 8'h18;
	localparam logic [7:0] OFF_OW_UNMASK = 8'h1C;
	localparam logic [7:0] OFF_OW_MASK = 8'h20;
	localparam logic [7:0] OFF_OW_STATE = 8'h24;
	localparam logic [31:0] RST_PULLUP_OFF = 32'h00000000;
	localparam logic [31:0] RST_FUNC_B = 32'h00000000;
	localparam logic [31:0] RST_OW_EN = 32'h00000000;
	localparam logic [31:0] RST_OUTLEVEL = 32'h00000000;
endpackage

/* verilog/iolm_setclr.sv */
// one bank of set/clear control bits with a status view
`timescale 1ns/10ps
module iolm_setclr #(
	parameter int W = 32,
	parameter logic [31:0] RSTVAL = 32'h00000000
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic setWr,
	input wire logic clrWr,
	input wire logic [W-1:0] wdata,
	output logic [W-1:0] state
);
	logic [W-1:0] bits_ff;
	logic [W-1:0] nxt_bits;
	// written zeros leave bits alone; set and clear are separate addresses
	assign nxt_bits = setWr ? (bits_ff | wdata) : clrWr ? (bits_ff & ~wdata) : bits_ff;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			bits_ff <= RSTVAL[W-1:0];
		else
			bits_ff <= nxt_bits;
	end
	assign state = bits_ff;
endmodule

/* verilog/iolm_outlevel.sv */
// output level register with per-line write mask
`timescale 1ns/10ps
module iolm_outlevel #(
	parameter int W = 32
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic wr,
	input wire logic [W-1:0] wdata,
	input wire logic [W-1:0] owEn,
	output logic [W-1:0] level
);
	logic [W-1:0] level_ff;
	logic [W-1:0] nxt_level;
	// masked lines keep their old level
	assign nxt_level = wr ? ((wdata & owEn) | (level_ff & ~owEn)) : level_ff;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			level_ff <= iolm_pkg::RST_OUTLEVEL[W-1:0];
		else
			level_ff <= nxt_level;
	end
	assign level = level_ff;
endmodule

/* verilog/iolm_top.sv */
// I/O line pull-up, function select and output write mask, APB slave
// Behaviour
// - pull-up state reads 0 when enabled, 1 when disabled
// - writing 1 to function A assign puts the line on function A
// - writing 1 to function B assign puts the line on function B
// - function select state reads 0 for A, 1 for B
// - writing 1 to unmask lets output level writes reach the line
// - writing 1 to mask blocks output level writes on the line
// - mask state reads 1 where writes reach; masked lines keep level
// - output level bit gives driven level, 0 low, 1 high
// - pull-up on and off registers set or clear pull-up; zeros ignored
`timescale 1ns/10ps
module iolm_top #(
	parameter int LINES = iolm_pkg::LINES
) (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic [LINES-1:0] outputLevel,
	output logic [LINES-1:0] pullupEnable,
	output logic [LINES-1:0] funcBSelect
);
	logic [LINES-1:0] pullupOff;
	logic [LINES-1:0] owEn;
	logic [LINES-1:0] wdat;
	logic wrStb;
	logic rdStb;
	logic [31:0] prdata_ff;
	logic [31:0] nxt_prdata;
	logic [31:0] rdMux;
	logic mapped;
	logic setupPhase;
	logic accessPhase;
	logic hitWrOnly;
	logic hitRdOnly;
	logic errUnmapped;
	logic errRdOfWo;
	logic errWrOfRo;
	logic wrOut;
	logic wrPuOn;
	logic wrPuOff;
	logic wrFa;
	logic wrFb;
	logic wrOwU;
	logic wrOwM;
	wire logic hitOut = paddr == iolm_pkg::OFF_OUTLEVEL;
	wire logic hitPuOn = paddr == iolm_pkg::OFF_PULLUP_ON;
	wire logic hitPuOff = paddr == iolm_pkg::OFF_PULLUP_OFF;
	wire logic hitPuSt = paddr == iolm_pkg::OFF_PULLUP_STATE;
	wire logic hitFa = paddr == iolm_pkg::OFF_FUNC_A;
	wire logic hitFb = paddr == iolm_pkg::OFF_FUNC_B;
	wire logic hitFSt = paddr == iolm_pkg::OFF_FUNC_STATE;
	wire logic hitOwU = paddr == iolm_pkg::OFF_OW_UNMASK;
	wire logic hitOwM = paddr == iolm_pkg::OFF_OW_MASK;
	wire logic hitOwSt = paddr == iolm_pkg::OFF_OW_STATE;

	// single-cycle access phase: no wait states
	assign pready = 1'h1;
	assign setupPhase = psel && !penable;
	assign accessPhase = psel && penable;
	assign wrStb = accessPhase && pwrite;
	assign rdStb = setupPhase && !pwrite;
	assign wdat = pwdata[LINES-1:0];
	assign hitWrOnly = hitPuOn | hitPuOff | hitFa | hitFb | hitOwU | hitOwM;
	assign hitRdOnly = hitPuSt | hitFSt | hitOwSt;
	assign mapped = hitOut | hitWrOnly | hitRdOnly;
	// unmapped addresses and wrong-direction accesses answer with an error
	assign errUnmapped = !mapped;
	assign errRdOfWo = !pwrite && hitWrOnly;
	assign errWrOfRo = pwrite && hitRdOnly;
	assign pslverr = accessPhase && (errUnmapped || errRdOfWo || errWrOfRo);
	// one strobe per writable word; refused writes reach no bank
	assign wrOut = wrStb && hitOut;
	assign wrPuOn = wrStb && hitPuOn;
	assign wrPuOff = wrStb && hitPuOff;
	assign wrFa = wrStb && hitFa;
	assign wrFb = wrStb && hitFb;
	assign wrOwU = wrStb && hitOwU;
	assign wrOwM = wrStb && hitOwM;

	// pull-up bank stores the disable sense so it reads back directly
	iolm_setclr #(.W(LINES), .RSTVAL(iolm_pkg::RST_PULLUP_OFF)) uPullup (
		.clk(clk),
		.rstn(rstn),
		.setWr(wrPuOff),
		.clrWr(wrPuOn),
		.wdata(wdat),
		.state(pullupOff)
	);

	iolm_setclr #(.W(LINES), .RSTVAL(iolm_pkg::RST_FUNC_B)) uFunc (
		.clk(clk),
		.rstn(rstn),
		.setWr(wrFb),
		.clrWr(wrFa),
		.wdata(wdat),
		.state(funcBSelect)
	);

	iolm_setclr #(.W(LINES), .RSTVAL(iolm_pkg::RST_OW_EN)) uOwMask (
		.clk(clk),
		.rstn(rstn),
		.setWr(wrOwU),
		.clrWr(wrOwM),
		.wdata(wdat),
		.state(owEn)
	);

	iolm_outlevel #(.W(LINES)) uOut (
		.clk(clk),
		.rstn(rstn),
		.wr(wrOut),
		.wdata(wdat),
		.owEn(owEn),
		.level(outputLevel)
	);

	assign pullupEnable = ~pullupOff;

	// status words, upper bits zero when fewer lines are built
	assign rdMux = hitPuSt ? 32'(pullupOff)
		: hitFSt ? 32'(funcBSelect)
		: hitOwSt ? 32'(owEn)
		: hitOut ? 32'(outputLevel)
		: 32'h00000000;
	// data captured in setup so prdata comes from a flip-flop
	assign nxt_prdata = rdStb ? rdMux : prdata_ff;
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
			prdata_ff <= 32'h00000000;
		else
			prdata_ff <= nxt_prdata;
	end
	assign prdata = prdata_ff;
endmodule

/* bench/iolm_sva.sv */
// checker for the I/O line mux block
`timescale 1ns/10ps
module iolm_chk (
	input wire logic clk,
	input wire logic rstn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic [31:0] outputLevel,
	input wire logic [31:0] pullupEnable,
	input wire logic [31:0] funcBSelect
);
	wire wr = psel && penable && pwrite;
	wire rd = psel && penable && !pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	property p_on; wr && paddr == 8'h04 |=> &(pullupEnable | ~$past(pwdata)); endproperty
	a_on: assert property (p_on) else $error("pu set");
	property p_off; wr && paddr == 8'h08 |=> !(|(pullupEnable & $past(pwdata))); endproperty
	a_off: assert property (p_off) else $error("pu clr");
	property p_a; wr && paddr == 8'h10 |=> !(|(funcBSelect & $past(pwdata))); endproperty
	a_a: assert property (p_a) else $error("to A");
	property p_b; wr && paddr == 8'h14 |=> &(funcBSelect | ~$past(pwdata)); endproperty
	a_b: assert property (p_b) else $error("to B");
	property p_pu; rd && paddr == 8'h0C |-> prdata == ~pullupEnable; endproperty
	a_pu: assert property (p_pu) else $error("pu read");
	property p_ab; rd && paddr == 8'h18 |-> prdata == funcBSelect; endproperty
	a_ab: assert property (p_ab) else $error("ab read");
	property p_ol; !(wr && paddr == 8'h00) |=> $stable(outputLevel); endproperty
	a_ol: assert property (p_ol) else $error("level");
	property p_rst;
		$rose(rstn) |-> &pullupEnable && !(|funcBSelect) && outputLevel == 32'h00000000;
	endproperty
	a_rst: assert property (p_rst) else $error("reset");
	sequence s_ro_write;
		psel && !penable && pwrite && (paddr == 8'h0C || paddr == 8'h18 || paddr == 8'h24)
		##1 psel && penable;
	endsequence
	property p_dir; s_ro_write |-> pslverr; endproperty
	a_dir: assert property (p_dir) else $error("ro write");
	property p_hold; !(psel && !penable && !pwrite) |=> $stable(prdata); endproperty
	a_hold: assert property (p_hold) else $error("rd hold");
endmodule
bind iolm_top iolm_chk chk (
	.clk(clk),
	.rstn(rstn),
	.psel(psel),
	.penable(penable),
	.pwrite(pwrite),
	.paddr(paddr),
	.pwdata(pwdata),
	.prdata(prdata),
	.pslverr(pslverr),
	.outputLevel(outputLevel),
	.pullupEnable(pullupEnable),
	.funcBSelect(funcBSelect)
);

/* bench/test_iolm_top.sv */
// bench for the I/O line mux block
`timescale 1ns/10ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin n_fail++; \
	$display("unexpected %0t %h %h", $time, g, e); end end
module test_iolm_top;
	logic clk = 1'h0, rstn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, outputLevel, pullupEnable, funcBSelect, q[$];
	logic [31:0] ol = 32'h0, pu = 32'h0, fb = 32'h0, ow = 32'h0, sd = 32'h3C;
	int compares = 0, n_fail = 0, cyc = 0;
	logic qe[$];
	iolm_top dut (
		.clk(clk),
		.rstn(rstn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.outputLevel(outputLevel),
		.pullupEnable(pullupEnable),
		.funcBSelect(funcBSelect)
	);
	initial forever #20 clk = ~clk;
	function automatic logic [31:0] rnd();
		sd ^= sd << 13;
		sd ^= sd >> 17;
		sd ^= sd << 5;
		return sd;
	endfunction
	// error answer expected from the register map and the access direction
	function automatic logic experr(input logic [7:0] a, input logic w);
		logic ro;
		logic wo;
		ro = a == 8'h0C || a == 8'h18 || a == 8'h24;
		wo = a == 8'h04 || a == 8'h08 || a == 8'h10 || a == 8'h14 || a == 8'h1C || a == 8'h20;
		return !(ro || wo || a == 8'h00) || (w && ro) || (!w && wo);
	endfunction
	task end_sim();
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task xfer(input logic [7:0] a, input logic [31:0] d, input logic w);
		if (!w)
			q.push_back(a == 8'h00 ? ol : a == 8'h0C ? pu : a == 8'h18 ? fb : ow);
		qe.push_back(experr(a, w));
		psel <= 1'h1;
		penable <= 1'h0;
		paddr <= a;
		pwdata <= d;
		pwrite <= w;
		@(posedge clk);
		penable <= 1'h1;
		do @(posedge clk); while (pready !== 1'h1);
		if (w)
			case (a)
				8'h00: ol = (ol & ~ow) | (d & ow);
				8'h04: pu &= ~d;
				8'h08: pu |= d;
				8'h10: fb &= ~d;
				8'h14: fb |= d;
				8'h1C: ow |= d;
				8'h20: ow &= ~d;
				default: ;
			endcase
	endtask
	always @(posedge clk)
	begin
		if (psel && penable)
		begin
			`CHK(pslverr, qe[0])
			qe.delete(0);
		end
		if (psel && penable && !pwrite)
		begin
			`CHK(prdata, q[0])
			q.delete(0);
			`CHK(outputLevel, ol)
			`CHK(pullupEnable, ~pu)
			`CHK(funcBSelect, fb)
		end
		if (++cyc == 3000)
		begin
			n_fail++;
			end_sim();
		end
	end
	initial
	begin
		repeat (20) @(posedge clk);
		rstn <= 1'h1;
		// read-only and unmapped offsets are written too; they must change nothing
		repeat (5)
			for (int i = 0; i < 11; i++)
			begin
				xfer(8'(i * 4), rnd(), 1'h1);
				for (int j = 0; j < 4; j++)
					xfer(8'(j * 12), 32'h0, 1'h0);
			end
		$display("random traffic done");
		// bus goes idle before reset so no stale access follows the release
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
		rstn <= 1'h0;
		repeat (2) @(posedge clk);
		rstn <= 1'h1;
		ol = 32'h00000000;
		pu = 32'h00000000;
		fb = 32'h00000000;
		ow = 32'h00000000;
		for (int j = 0; j < 4; j++)
			xfer(8'(j * 12), 32'h0, 1'h0);
		xfer(8'h14, 32'h0000000F, 1'h1);
		xfer(8'h18, 32'h0, 1'h0);
		$display("reset test done");
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge clk);
		@(negedge clk);
		end_sim();
	end
endmodule
